// ==== csc_pkg.sv ====
/*
  Constants, field layouts, offsets and types shared by the core special register bank.
  Assumes a single 10 MHz clock and an active high asynchronous reset at the top level.
*/
// Overview of operation
// - Internal code memory: one machine cycle minimum
// - External transfers overlap core, never stall it
// - Figures assume 20 MHz, zero wait states
// - Internal RAM: fetch 6/8, read 0/1, write 0
// - External bus costs per width and multiplexing
// - Indirect RAM, external operands, misaligned jumps in internal code memory lengthen
// - Register read right after write costs extra
// - Branch test after status word write costs extra
// - Core registers except the pointers share the common register path
// - Instruction and segment pointers change by branches only
// - Status, stack, multiply control: software and hardware
// - Software write beats simultaneous hardware update
// - Byte write clears the other byte
// - Unimplemented bits ignore writes, read zero
// - Configuration register: bit set, clear, test
// - Configuration reset from port zero; outer nibbles zero
// - Configuration register field layout
// - Configuration frozen after end of initialization
// - Stack size field selects 32 to 1024 words
// - Segmentation enabled saves segment and instruction pointers
`default_nettype none
package csc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CORE_REF_MHZ = 20;
  localparam int WAIT_STATES = 0;

  localparam logic [15:0] ADDR_SYS_CONFIG = 16'hff12;
  localparam logic [15:0] ADDR_STATUS_WORD = 16'hff10;
  localparam logic [15:0] ADDR_STACK_PTR = 16'hfe12;
  localparam logic [15:0] ADDR_MUL_DIV_CTRL = 16'hff0e;
  localparam logic [15:0] ADDR_INSTR_PTR = 16'hfe06;
  localparam logic [15:0] ADDR_CODE_SEG = 16'hfe08;

  localparam logic [15:0] MASK_SYS_CONFIG = 16'hefd7;
  localparam logic [15:0] MASK_STATUS_WORD = 16'hffff;
  localparam logic [15:0] MASK_STACK_PTR = 16'hfffe;
  localparam logic [15:0] MASK_MUL_DIV_CTRL = 16'h00ff;
  localparam logic [15:0] MASK_PORT_STRAP = 16'h0ff0;
  localparam logic [15:0] RST_SYS_CONFIG = 16'h0000;
  localparam logic [15:0] RST_STATUS_WORD = 16'h0000;
  localparam logic [15:0] RST_STACK_PTR = 16'hfc00;
  localparam logic [15:0] RST_MUL_DIV_CTRL = 16'h0000;
  localparam logic [7:0] RST_CODE_SEG = 8'h00;
  localparam logic [15:0] RST_INSTR_PTR = 16'h0000;

  localparam int STACK_SIZE_FIELD_MSB = 15;
  localparam int STACK_SIZE_FIELD_LSB = 13;
  localparam int BIT_SEG_DISABLE = 11;
  localparam int BIT_BOOT_ROM = 10;
  localparam int BIT_BYTE_HIGH_DIS = 9;
  localparam int BIT_CLK_OUT_EN = 8;
  localparam int BIT_WRITE_CFG = 7;
  localparam int BIT_CS_CFG = 6;
  localparam int BIT_OSC_WDT_EN = 4;
  localparam int BIT_XPER_EN = 2;
  localparam int BIT_VISIBLE = 1;
  localparam int BIT_SHARE = 0;

  localparam logic [10:0] STACK_MIN_WORDS = 11'd32;
  localparam logic [2:0] STACK_MAX_CODE = 3'h5;
  localparam logic [1:0] STRAP_DELAY = 2'h2;

  localparam logic [5:0] COST_IROM = 6'h01;
  localparam logic [5:0] COST_IRAM_FETCH_W = 6'h06;
  localparam logic [5:0] COST_IRAM_FETCH_D = 6'h08;
  localparam logic [5:0] COST_IRAM_IND_RD = 6'h01;
  localparam logic [5:0] COST_D16 = 6'h02;
  localparam logic [5:0] COST_M16 = 6'h03;
  localparam logic [5:0] COST_D8 = 6'h04;
  localparam logic [5:0] COST_M8 = 6'h06;
  localparam logic [5:0] COST_EXTRA = 6'h01;

  typedef enum logic [2:0] {
    AREA_IROM = 3'h0,
    AREA_IRAM = 3'h1,
    AREA_DEMUX16 = 3'h2,
    AREA_MUX16 = 3'h3,
    AREA_DEMUX8 = 3'h4,
    AREA_MUX8 = 3'h5
  } csc_area_t;

  typedef enum logic [1:0] {
    BITOP_NONE = 2'h0,
    BITOP_SET = 2'h1,
    BITOP_CLEAR = 2'h2,
    BITOP_TEST = 2'h3
  } csc_bitop_t;
endpackage
`default_nettype wire

// ==== csc_timing_if.sv ====
/*
  Carries one instruction's access profile to the state time estimator and its cost back.
  Assumes both ends run on the same clock; the estimator is purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
interface csc_timing_if;
  logic [2:0] fetch_area;
  logic fetch_dword;
  logic op_rd;
  logic op_wr;
  logic [2:0] op_area;
  logic ind_rd;
  logic misaligned_jmp;
  logic reg_read_after_write;
  logic branch_after_status;
  logic [5:0] units;
  logic ext_overlap;
  modport core (output fetch_area, fetch_dword, op_rd, op_wr, op_area, ind_rd, misaligned_jmp,
    reg_read_after_write, branch_after_status, input units, ext_overlap);
  modport est (input fetch_area, fetch_dword, op_rd, op_wr, op_area, ind_rd, misaligned_jmp,
    reg_read_after_write, branch_after_status, output units, ext_overlap);
endinterface
`default_nettype wire

// ==== csc_state_time.sv ====
/*
  Minimum instruction state time estimator, in the units of the access cost table.
  Assumes the profile is stable for the cycle in which the caller samples the result.
*/
`timescale 1ns/100ps
`default_nettype none
module csc_state_time (
  csc_timing_if.est tif
);
  // Word access cost of an external area; internal areas give zero here
  function automatic logic [5:0] area_cost(input logic [2:0] area);
    case (area)
      csc_pkg::AREA_DEMUX16: area_cost = csc_pkg::COST_D16;
      csc_pkg::AREA_MUX16: area_cost = csc_pkg::COST_M16;
      csc_pkg::AREA_DEMUX8: area_cost = csc_pkg::COST_D8;
      csc_pkg::AREA_MUX8: area_cost = csc_pkg::COST_M8;
      default: area_cost = 6'h00;
    endcase
  endfunction

  wire logic fetch_ext = tif.fetch_area >= csc_pkg::AREA_DEMUX16;
  wire logic op_ext = tif.op_area >= csc_pkg::AREA_DEMUX16;
  wire logic [5:0] ext_fetch_w = area_cost(tif.fetch_area);
  wire logic [5:0] fetch_cost = (tif.fetch_area == csc_pkg::AREA_IRAM) ?
    (tif.fetch_dword ? csc_pkg::COST_IRAM_FETCH_D : csc_pkg::COST_IRAM_FETCH_W) :
    (fetch_ext ? (tif.fetch_dword ? 6'(ext_fetch_w << 1) : ext_fetch_w) :
    csc_pkg::COST_IROM);
  // Internal RAM writes are free; reads cost only when indirect
  wire logic [5:0] rd_cost = !tif.op_rd ? 6'h00 : op_ext ? area_cost(tif.op_area) :
    ((tif.op_area == csc_pkg::AREA_IRAM && tif.ind_rd) ? csc_pkg::COST_IRAM_IND_RD : 6'h00);
  wire logic [5:0] wr_cost = (tif.op_wr && op_ext) ? area_cost(tif.op_area) : 6'h00;
  wire logic [5:0] extra = (tif.misaligned_jmp && tif.fetch_area == csc_pkg::AREA_IROM ? csc_pkg::COST_EXTRA : 6'h00) +
    (tif.reg_read_after_write ? csc_pkg::COST_EXTRA : 6'h00) +
    (tif.branch_after_status ? csc_pkg::COST_EXTRA : 6'h00);
  wire logic [5:0] total = 6'(fetch_cost + rd_cost + wr_cost + extra);

  // No instruction ever finishes under one machine cycle
  assign tif.units = (total < csc_pkg::COST_IROM) ? csc_pkg::COST_IROM : total;
  // External transfers are handed to the bus controller and overlap core work
  assign tif.ext_overlap = fetch_ext || ((tif.op_rd || tif.op_wr) && op_ext);
endmodule // csc_state_time
`default_nettype wire

// ==== csc_core_regs.sv ====
/*
  Core special register bank: configuration, status word, stack pointer, multiply/divide
  control and the hidden instruction and segment pointers, plus the state time estimate.
  Assumes the core drives the special register path on I_CLK; port zero pins are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module csc_core_regs (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [15:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  input wire logic I_SFR_BYTE,
  input wire logic [1:0] I_SFR_BIT_OP,
  input wire logic [3:0] I_SFR_BIT_SEL,
  input wire logic [15:0] I_SFR_WDATA,
  input wire logic I_HW_STATUS_WE,
  input wire logic [15:0] I_HW_STATUS,
  input wire logic I_HW_STACK_WE,
  input wire logic [15:0] I_HW_STACK,
  input wire logic I_HW_MDC_WE,
  input wire logic [15:0] I_HW_MDC,
  input wire logic I_BRANCH_WE,
  input wire logic [15:0] I_BRANCH_IP,
  input wire logic [7:0] I_BRANCH_CSP,
  input wire logic I_BRANCH_TEST,
  input wire logic I_END_OF_INIT,
  input wire logic [15:0] I_PORT_ZERO,
  input wire logic I_INSTR_VALID,
  input wire logic [2:0] I_FETCH_AREA,
  input wire logic I_FETCH_DWORD,
  input wire logic I_OP_RD,
  input wire logic I_OP_WR,
  input wire logic [2:0] I_OP_AREA,
  input wire logic I_IND_RD,
  input wire logic I_MISALIGNED_JMP,
  output logic [15:0] O_SFR_RDATA,
  output logic O_SFR_BIT_VAL,
  output logic [15:0] O_SYS_CONFIG,
  output logic [15:0] O_STATUS_WORD,
  output logic [15:0] O_STACK_PTR,
  output logic [15:0] O_MDC,
  output logic [15:0] O_INSTR_PTR,
  output logic [7:0] O_CODE_SEG,
  output logic [10:0] O_STACK_WORDS,
  output logic O_SAVE_SEGMENT,
  output logic O_CONFIG_LOCKED,
  output logic [5:0] O_STATE_UNITS,
  output logic O_EXT_OVERLAP,
  output logic O_STATE_VALID
);
  // Word that results from a software write: byte writes zero the other byte
  function automatic logic [15:0] sw_word(input logic [15:0] wdata, input logic is_byte, input logic hi);
    if (!is_byte) begin
      sw_word = wdata;
    end else if (hi) begin
      sw_word = {wdata[7:0], 8'h00};
    end else begin
      sw_word = {8'h00, wdata[7:0]};
    end
  endfunction

  // Software wins over a hardware update in the same cycle, then unimplemented bits drop
  function automatic logic [15:0] merge(input logic sw_we, input logic [15:0] sw_val, input logic hw_we,
    input logic [15:0] hw_val, input logic [15:0] cur, input logic [15:0] mask);
    merge = (sw_we ? sw_val : (hw_we ? hw_val : cur)) & mask;
  endfunction

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] reg_addr);
    hit = addr[15:1] == reg_addr[15:1];
  endfunction

  logic [15:0] sys_config;
  logic [15:0] status_word;
  logic [15:0] stack_ptr;
  logic [15:0] mdc;
  logic [15:0] instr_ptr;
  logic [7:0] code_seg;
  logic config_locked;
  logic [15:0] port_meta;
  logic [15:0] port_sync;
  logic [1:0] strap_cnt;
  logic strap_done;
  logic [15:0] last_wr_addr;
  logic last_wr_valid;
  logic status_sw_written;

  csc_timing_if tif ();

  csc_state_time u_state_time (
    .tif(tif)
  );

  // All core registers except the instruction and segment pointers decode through the one shared path
  wire logic sel_cfg = hit(I_SFR_ADDR, csc_pkg::ADDR_SYS_CONFIG);
  wire logic sel_psw = hit(I_SFR_ADDR, csc_pkg::ADDR_STATUS_WORD);
  wire logic sel_sp = hit(I_SFR_ADDR, csc_pkg::ADDR_STACK_PTR);
  wire logic sel_mdc = hit(I_SFR_ADDR, csc_pkg::ADDR_MUL_DIV_CTRL);
  wire logic byte_hi = I_SFR_BYTE && I_SFR_ADDR[0];

  wire logic bit_set = I_SFR_BIT_OP == csc_pkg::BITOP_SET;
  wire logic bit_clr = I_SFR_BIT_OP == csc_pkg::BITOP_CLEAR;
  wire logic bit_tst = I_SFR_BIT_OP == csc_pkg::BITOP_TEST;
  wire logic [15:0] bit_mask = 16'h0001 << I_SFR_BIT_SEL;

  // Bit operations are only honoured on the configuration register
  wire logic cfg_bit_we = sel_cfg && (bit_set || bit_clr);
  wire logic [15:0] cfg_bit_val = bit_set ? (sys_config | bit_mask) : (sys_config & ~bit_mask);
  wire logic [15:0] wr_word = sw_word(I_SFR_WDATA, I_SFR_BYTE, byte_hi);

  // Frozen after end of initialization; the instruction itself is not delayed
  wire logic cfg_sw_we = !config_locked && ((I_SFR_WR && sel_cfg) || cfg_bit_we);
  wire logic [15:0] cfg_sw_val = cfg_bit_we ? cfg_bit_val : wr_word;
  wire logic psw_sw_we = I_SFR_WR && sel_psw;
  wire logic sp_sw_we = I_SFR_WR && sel_sp;
  wire logic mdc_sw_we = I_SFR_WR && sel_mdc;

  // Strap levels fill only the middle byte; outer nibbles stay zero
  wire logic strap_load = !strap_done && strap_cnt == csc_pkg::STRAP_DELAY;
  wire logic [15:0] strap_val = (port_sync & csc_pkg::MASK_PORT_STRAP) | csc_pkg::RST_SYS_CONFIG;

  wire logic [15:0] next_sys_config = strap_load ? (strap_val & csc_pkg::MASK_SYS_CONFIG) :
    merge(cfg_sw_we, cfg_sw_val, 1'b0, 16'h0000, sys_config, csc_pkg::MASK_SYS_CONFIG);
  wire logic [15:0] next_status_word = merge(psw_sw_we, wr_word, I_HW_STATUS_WE, I_HW_STATUS, status_word,
    csc_pkg::MASK_STATUS_WORD);
  wire logic [15:0] next_stack_ptr = merge(sp_sw_we, wr_word, I_HW_STACK_WE, I_HW_STACK, stack_ptr,
    csc_pkg::MASK_STACK_PTR);
  wire logic [15:0] next_mdc = merge(mdc_sw_we, wr_word, I_HW_MDC_WE, I_HW_MDC, mdc,
    csc_pkg::MASK_MUL_DIV_CTRL);

  // Pointer addresses fall through to the zero default: no direct access at all
  wire logic [15:0] rd_word = sel_cfg ? sys_config : sel_psw ? status_word : sel_sp ? stack_ptr :
    sel_mdc ? mdc : 16'h0000;
  wire logic [15:0] next_rdata = !I_SFR_BYTE ? rd_word :
    (byte_hi ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]});
  wire logic next_bit_val = |(sys_config & bit_mask);

  // Branches load a zero segment pointer while segmentation is disabled
  wire logic seg_disabled = sys_config[csc_pkg::BIT_SEG_DISABLE];
  wire logic [7:0] next_code_seg = seg_disabled ? 8'h00 : I_BRANCH_CSP;
  wire logic [2:0] stk_code = sys_config[csc_pkg::STACK_SIZE_FIELD_MSB:csc_pkg::STACK_SIZE_FIELD_LSB];
  wire logic [2:0] stk_shift = (stk_code > csc_pkg::STACK_MAX_CODE) ? csc_pkg::STACK_MAX_CODE : stk_code;
  wire logic [10:0] next_stack_words = csc_pkg::STACK_MIN_WORDS << stk_shift;

  wire logic raw_hit = I_SFR_RD && last_wr_valid && (I_SFR_ADDR[15:1] == last_wr_addr[15:1]);

  assign tif.fetch_area = I_FETCH_AREA;
  assign tif.fetch_dword = I_FETCH_DWORD;
  assign tif.op_rd = I_OP_RD;
  assign tif.op_wr = I_OP_WR;
  assign tif.op_area = I_OP_AREA;
  assign tif.ind_rd = I_IND_RD;
  assign tif.misaligned_jmp = I_MISALIGNED_JMP;
  assign tif.reg_read_after_write = raw_hit;
  assign tif.branch_after_status = I_BRANCH_TEST && status_sw_written;

  // Port zero pins are asynchronous: two stages before anything reads them
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      port_meta <= 16'h0000;
      port_sync <= 16'h0000;
    end else begin
      port_meta <= I_PORT_ZERO;
      port_sync <= port_meta;
    end
  end

  // Straps are caught once the synchroniser has refilled after reset release
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt <= 2'(strap_cnt + 2'h1);
      strap_done <= strap_load;
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sys_config <= csc_pkg::RST_SYS_CONFIG;
      status_word <= csc_pkg::RST_STATUS_WORD;
      stack_ptr <= csc_pkg::RST_STACK_PTR;
      mdc <= csc_pkg::RST_MUL_DIV_CTRL;
    end else begin
      sys_config <= next_sys_config;
      status_word <= next_status_word;
      stack_ptr <= next_stack_ptr;
      mdc <= next_mdc;
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      config_locked <= 1'b0;
    end else if (I_END_OF_INIT) begin
      config_locked <= 1'b1;
    end
  end

  // Only branches move the pointers
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      instr_ptr <= csc_pkg::RST_INSTR_PTR;
      code_seg <= csc_pkg::RST_CODE_SEG;
    end else if (I_BRANCH_WE) begin
      instr_ptr <= I_BRANCH_IP;
      code_seg <= next_code_seg;
    end
  end

  // History for the one-cycle pipeline penalties
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      last_wr_addr <= 16'h0000;
      last_wr_valid <= 1'b0;
      status_sw_written <= 1'b0;
    end else begin
      last_wr_addr <= I_SFR_ADDR;
      last_wr_valid <= I_SFR_WR || cfg_bit_we;
      status_sw_written <= psw_sw_we;
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_SFR_RDATA <= 16'h0000;
      O_SFR_BIT_VAL <= 1'b0;
    end else begin
      if (I_SFR_RD) begin
        O_SFR_RDATA <= next_rdata;
      end
      if (sel_cfg && bit_tst) begin
        O_SFR_BIT_VAL <= next_bit_val;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_STACK_WORDS <= csc_pkg::STACK_MIN_WORDS;
      O_SAVE_SEGMENT <= 1'b1;
    end else begin
      O_STACK_WORDS <= next_stack_words;
      O_SAVE_SEGMENT <= !seg_disabled;
    end
  end

  // Estimate is registered so every output comes from a flop
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_STATE_UNITS <= 6'h00;
      O_EXT_OVERLAP <= 1'b0;
      O_STATE_VALID <= 1'b0;
    end else begin
      O_STATE_VALID <= I_INSTR_VALID;
      if (I_INSTR_VALID) begin
        O_STATE_UNITS <= tif.units;
        O_EXT_OVERLAP <= tif.ext_overlap;
      end
    end
  end

  assign O_SYS_CONFIG = sys_config;
  assign O_STATUS_WORD = status_word;
  assign O_STACK_PTR = stack_ptr;
  assign O_MDC = mdc;
  assign O_INSTR_PTR = instr_ptr;
  assign O_CODE_SEG = code_seg;
  assign O_CONFIG_LOCKED = config_locked;
endmodule // csc_core_regs
`default_nettype wire

// ==== csc_core_regs_monitor.sv ====
/*
  Concurrent checks on the ports of csc_core_regs, attached by bind.
  Assumes the single I_CLK domain and the active high asynchronous I_SYS_RST.
*/
`timescale 1ns/100ps
`default_nettype none
module csc_core_regs_monitor (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [15:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  input wire logic I_SFR_BYTE,
  input wire logic [15:0] I_SFR_WDATA,
  input wire logic I_BRANCH_WE,
  input wire logic I_BRANCH_TEST,
  input wire logic I_END_OF_INIT,
  input wire logic I_INSTR_VALID,
  input wire logic [2:0] I_FETCH_AREA,
  input wire logic I_FETCH_DWORD,
  input wire logic I_OP_RD,
  input wire logic I_OP_WR,
  input wire logic I_MISALIGNED_JMP,
  input wire logic [15:0] O_SFR_RDATA,
  input wire logic [15:0] O_SYS_CONFIG,
  input wire logic [15:0] O_STATUS_WORD,
  input wire logic [15:0] O_STACK_PTR,
  input wire logic [15:0] O_MDC,
  input wire logic [15:0] O_INSTR_PTR,
  input wire logic O_CONFIG_LOCKED,
  input wire logic [5:0] O_STATE_UNITS,
  input wire logic O_STATE_VALID
);
  default clocking dc @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  property p_valid_follows; I_INSTR_VALID |=> O_STATE_VALID; endproperty
  a_valid_follows: assert property (p_valid_follows) else $error("state valid missing");
  property p_valid_pulse; !I_INSTR_VALID |=> !O_STATE_VALID; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("stray state valid");
  // Penalties excluded: base fetch cost only
  property p_rom_single;
    I_INSTR_VALID && I_FETCH_AREA == 3'h0 && !I_OP_RD && !I_OP_WR && !I_MISALIGNED_JMP && !I_BRANCH_TEST
      && !I_SFR_RD |=> O_STATE_UNITS == 6'h01;
  endproperty
  a_rom_single: assert property (p_rom_single) else $error("rom fetch cost");
  property p_iram_fetch;
    I_INSTR_VALID && I_FETCH_AREA == 3'h1 && !I_OP_RD && !I_OP_WR && !I_BRANCH_TEST && !I_SFR_RD
      |=> O_STATE_UNITS == ($past(I_FETCH_DWORD) ? 6'h08 : 6'h06);
  endproperty
  a_iram_fetch: assert property (p_iram_fetch) else $error("ram fetch cost");
  property p_hidden_read;
    I_SFR_RD && (I_SFR_ADDR[15:1] == 15'h7f03 || I_SFR_ADDR[15:1] == 15'h7f04) |=> O_SFR_RDATA == 16'h0000;
  endproperty
  a_hidden_read: assert property (p_hidden_read) else $error("hidden pointer readable");
  property p_ip_branch_only; !I_BRANCH_WE |=> $stable(O_INSTR_PTR); endproperty
  a_ip_branch_only: assert property (p_ip_branch_only) else $error("pointer moved");
  property p_sw_wins;
    I_SFR_WR && !I_SFR_BYTE && I_SFR_ADDR == 16'hff10 |=> O_STATUS_WORD == $past(I_SFR_WDATA);
  endproperty
  a_sw_wins: assert property (p_sw_wins) else $error("status word write lost");
  property p_byte_clears; I_SFR_WR && I_SFR_BYTE && I_SFR_ADDR == 16'hff10 |=> O_STATUS_WORD[15:8] == 8'h00;
  endproperty
  a_byte_clears: assert property (p_byte_clears) else $error("other byte not cleared");
  property p_reserved_zero;
    (O_SYS_CONFIG & 16'h1028) == 16'h0000 && !O_STACK_PTR[0] && O_MDC[15:8] == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
  property p_config_write;
    I_SFR_WR && !I_SFR_BYTE && I_SFR_ADDR == 16'hff12 && !O_CONFIG_LOCKED
      |=> O_SYS_CONFIG == ($past(I_SFR_WDATA) & 16'hefd7);
  endproperty
  a_config_write: assert property (p_config_write) else $error("config write wrong");
  property p_lock_sets; I_END_OF_INIT |=> O_CONFIG_LOCKED; endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("lock not taken");
  property p_lock_holds; O_CONFIG_LOCKED |=> O_CONFIG_LOCKED && $stable(O_SYS_CONFIG); endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("config changed after lock");
endmodule // csc_core_regs_monitor

bind csc_core_regs csc_core_regs_monitor u_csc_core_regs_monitor (.*);
`default_nettype wire

// ==== test_csc_core_regs.sv ====
/*
  Self-checking bench for csc_core_regs.
  Assumes csc_pkg and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module test_csc_core_regs;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [15:0] addr, wdata, hw_val, bip, port_zero, sfr_rdata, sys_config, status, stack, mdc, ip;
  logic wr, rd, byte_m, hw_st, hw_sp, hw_md, br_we, br_test, eoi, valid, fdw, op_rd, op_wr, ind, mis;
  logic bit_val, save_seg, locked, ovl, st_valid;
  logic [1:0] bit_op;
  logic [3:0] bit_sel;
  logic [7:0] bcsp, code_segment_pointer;
  logic [2:0] farea, oarea;
  logic [10:0] stk_words;
  logic [5:0] units;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  csc_core_regs u_csc_core_regs (.I_CLK(clk), .I_SYS_RST(rst), .I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_RD(rd),
    .I_SFR_BYTE(byte_m), .I_SFR_BIT_OP(bit_op), .I_SFR_BIT_SEL(bit_sel), .I_SFR_WDATA(wdata),
    .I_HW_STATUS_WE(hw_st), .I_HW_STATUS(hw_val), .I_HW_STACK_WE(hw_sp), .I_HW_STACK(hw_val),
    .I_HW_MDC_WE(hw_md), .I_HW_MDC(hw_val), .I_BRANCH_WE(br_we), .I_BRANCH_IP(bip), .I_BRANCH_CSP(bcsp),
    .I_BRANCH_TEST(br_test), .I_END_OF_INIT(eoi), .I_PORT_ZERO(port_zero), .I_INSTR_VALID(valid),
    .I_FETCH_AREA(farea), .I_FETCH_DWORD(fdw), .I_OP_RD(op_rd), .I_OP_WR(op_wr), .I_OP_AREA(oarea),
    .I_IND_RD(ind), .I_MISALIGNED_JMP(mis), .O_SFR_RDATA(sfr_rdata), .O_SFR_BIT_VAL(bit_val),
    .O_SYS_CONFIG(sys_config), .O_STATUS_WORD(status), .O_STACK_PTR(stack), .O_MDC(mdc), .O_INSTR_PTR(ip),
    .O_CODE_SEG(code_segment_pointer), .O_STACK_WORDS(stk_words), .O_SAVE_SEGMENT(save_seg), .O_CONFIG_LOCKED(locked),
    .O_STATE_UNITS(units), .O_EXT_OVERLAP(ovl), .O_STATE_VALID(st_valid));

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic drv(input logic [15:0] a, input logic [15:0] d, input logic w, input logic b,
      input logic [2:0] hw, input logic [15:0] hv);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = w;
    byte_m = b;
    {hw_md, hw_sp, hw_st} = hw;
    hw_val = hv;
    @(negedge clk);
    {wr, byte_m, hw_md, hw_sp, hw_st} = 5'h00;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'h1;
    @(negedge clk);
    rd = 1'h0;
    chk16(sfr_rdata, exp, "read data");
  endtask

  task automatic bop(input logic [1:0] op, input logic [3:0] sel);
    @(negedge clk);
    addr = 16'hff12;
    bit_op = op;
    bit_sel = sel;
    @(negedge clk);
    bit_op = 2'h0;
  endtask

  task automatic est(input logic [2:0] fa, input logic fd, input logic [1:0] rw, input logic [2:0] oa,
      input logic [1:0] im, input logic [5:0] exp);
    @(negedge clk);
    valid = 1'h1;
    farea = fa;
    fdw = fd;
    {op_rd, op_wr} = rw;
    oarea = oa;
    {ind, mis} = im;
    @(negedge clk);
    valid = 1'h0;
    chk1(st_valid, 1'h1, "state valid");
    chk16({10'h000, units}, {10'h000, exp}, "state units");
  endtask

  // Status word write, then a read of it or a branch test
  task automatic pen(input logic br);
    @(negedge clk);
    addr = 16'hff10;
    wdata = 16'h0000;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
    rd = ~br;
    br_test = br;
    valid = 1'h1;
    farea = 3'h0;
    fdw = 1'h0;
    @(negedge clk);
    {rd, br_test, valid} = 3'h0;
    chk16({10'h000, units}, 16'h0002, "penalty units");
  endtask

  task automatic t_reset();
    chk16(stack, 16'hfc00, "stack in reset");
    chk16({5'h00, stk_words}, 16'h0020, "stack words reset");
    chk1(save_seg, 1'h1, "save seg reset");
    @(negedge clk);
    rst = 1'h0;
    // Straps land on the third edge after release
    repeat (4) @(negedge clk);
    chk16(sys_config, 16'h0fd0, "strap load");
    @(negedge clk);
    chk1(save_seg, 1'h0, "seg disabled");
    rdc(16'hff12, 16'h0fd0);
  endtask

  task automatic t_config();
    drv(16'hff12, 16'hffff, 1'h1, 1'h0, 3'h0, 16'h0000);
    chk16(sys_config, 16'hefd7, "reserved config bits");
    @(negedge clk);
    chk16({5'h00, stk_words}, 16'h0400, "largest stack");
    drv(16'hff12, 16'h4000, 1'h1, 1'h0, 3'h0, 16'h0000);
    @(negedge clk);
    chk16({5'h00, stk_words}, 16'h0080, "stack code two");
    chk1(save_seg, 1'h1, "seg enabled");
    bop(2'h1, 4'h8);
    chk16(sys_config, 16'h4100, "bit set");
    bop(2'h3, 4'h8);
    chk1(bit_val, 1'h1, "bit test");
    bop(2'h2, 4'h8);
    chk16(sys_config, 16'h4000, "bit clear");
    bop(2'h1, 4'hc);
    chk16(sys_config, 16'h4000, "reserved bit set");
    bop(2'h3, 4'hc);
    chk1(bit_val, 1'h0, "reserved bit test");
    drv(16'hff13, 16'h0020, 1'h1, 1'h1, 3'h0, 16'h0000);
    chk16(sys_config, 16'h2000, "config high byte");
  endtask

  task automatic t_core();
    drv(16'hff10, 16'hffff, 1'h1, 1'h0, 3'h0, 16'h0000);
    drv(16'hff10, 16'h0034, 1'h1, 1'h1, 3'h0, 16'h0000);
    chk16(status, 16'h0034, "low byte write");
    drv(16'hff11, 16'h0056, 1'h1, 1'h1, 3'h0, 16'h0000);
    chk16(status, 16'h5600, "high byte write");
    drv(16'hff10, 16'h1234, 1'h1, 1'h0, 3'h1, 16'ha5a5);
    chk16(status, 16'h1234, "sw wins");
    drv(16'hff10, 16'h0000, 1'h0, 1'h0, 3'h7, 16'ha5a5);
    chk16(status, 16'ha5a5, "hardware status");
    chk16(stack, 16'ha5a4, "hardware stack");
    chk16(mdc, 16'h00a5, "hardware mul div");
    drv(16'hfe12, 16'hffff, 1'h1, 1'h0, 3'h2, 16'h0100);
    chk16(stack, 16'hfffe, "stack sw wins");
    drv(16'hff0e, 16'hffff, 1'h1, 1'h0, 3'h4, 16'h0011);
    chk16(mdc, 16'h00ff, "mdc sw wins");
    rdc(16'hfe12, 16'hfffe);
  endtask

  task automatic t_hidden();
    drv(16'hfe06, 16'h1234, 1'h1, 1'h0, 3'h0, 16'h0000);
    drv(16'hfe08, 16'h0012, 1'h1, 1'h0, 3'h0, 16'h0000);
    chk16(ip, 16'h0000, "pointer write refused");
    chk16({8'h00, code_segment_pointer}, 16'h0000, "segment write refused");
    @(negedge clk);
    br_we = 1'h1;
    bip = 16'h0abc;
    bcsp = 8'h5a;
    @(negedge clk);
    br_we = 1'h0;
    chk16(ip, 16'h0abc, "branch pointer");
    chk16({8'h00, code_segment_pointer}, 16'h005a, "branch segment");
    rdc(16'hfe06, 16'h0000);
    rdc(16'hfe08, 16'h0000);
    rdc(16'hff00, 16'h0000);
  endtask

  task automatic t_timing();
    logic [5:0] w [6];
    w = '{6'h01, 6'h06, 6'h02, 6'h03, 6'h04, 6'h06};
    for (int a = 0; a < 6; a++) begin
      for (int d = 0; d < 2; d++) begin
        est(3'(a), 1'(d), 2'h0, 3'h0, 2'h0, (a < 2) ? w[a] + 6'(2 * a * d) : w[a] << d);
        chk1(ovl, 1'(a >= 2), "bus overlap");
      end
    end
    pen(1'h0);
    pen(1'h1);
    est(3'h0, 1'h0, 2'h2, 3'h3, 2'h0, 6'h04);
    est(3'h0, 1'h0, 2'h1, 3'h5, 2'h0, 6'h07);
    est(3'h1, 1'h0, 2'h1, 3'h1, 2'h0, 6'h06);
    est(3'h0, 1'h0, 2'h2, 3'h1, 2'h2, 6'h02);
    est(3'h0, 1'h1, 2'h0, 3'h0, 2'h1, 6'h02);
  endtask

  task automatic t_lock();
    @(negedge clk);
    eoi = 1'h1;
    @(negedge clk);
    eoi = 1'h0;
    chk1(locked, 1'h1, "lock flag");
    drv(16'hff12, 16'h0000, 1'h1, 1'h0, 3'h0, 16'h0000);
    bop(2'h1, 4'h0);
    chk16(sys_config, 16'h2000, "config frozen");
  endtask

  initial begin
    {wr, rd, byte_m, hw_st, hw_sp, hw_md, br_we, br_test, eoi, valid, fdw, op_rd, op_wr, ind, mis} = '0;
    {addr, wdata, hw_val, bip, bit_op, bit_sel, bcsp, farea, oarea} = '0;
    port_zero = 16'hffff;
    repeat (3) @(negedge clk);
    t_reset();
    t_config();
    t_core();
    t_hidden();
    t_timing();
    t_lock();
    finish_test();
  end
endmodule // test_csc_core_regs
`default_nettype wire
